/* File: common/dcm_pkg.sv */
// Package: constants, types and helpers of the dual counter mode control block
package dcm_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam int          AW               = 8;
  localparam int          DW               = 8;
  localparam logic [7:0]  ADDR_CNT_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_COMMON      = 8'h01;
  localparam logic [7:0]  ADDR_SHORT_RLD   = 8'h02;
  localparam logic [7:0]  ADDR_LONG_RLD_LO = 8'h03;
  localparam logic [7:0]  ADDR_LONG_RLD_HI = 8'h04;
  localparam logic [7:0]  ADDR_CAP_LO      = 8'h05;
  localparam logic [7:0]  ADDR_CAP_HI      = 8'h06;
  localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'h07;
  localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h08;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CC_SHORT_EN = 7;
  localparam int CC_LONG_EN  = 6;
  localparam int CC_CAP_IE   = 2;
  localparam int CC_CNT_IE   = 1;
  localparam int CC_PIN4_SEL = 0;
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_CAPTURE = 1;
  localparam int IRQ_W       = 2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0]  COMMON_RST    = 8'h00;
  localparam logic [7:0]  CNT_CTRL_RST  = 8'h00;
  localparam logic [7:0]  SHORT_RLD_RST = 8'hff;
  localparam logic [15:0] LONG_RLD_RST  = 16'hffff;

  // ----------------------------------------
  // Field encodings
  // ----------------------------------------
  localparam logic [1:0] FN_AND   = 2'h0;
  localparam logic [1:0] FN_OR    = 2'h1;
  localparam logic [1:0] FN_NOR   = 2'h2;
  localparam logic [1:0] FN_NAND  = 2'h3;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [1:0] SUB_NORMAL   = 2'h0;
  localparam logic [1:0] SUB_PINGPONG = 2'h1;
  localparam logic [1:0] SUB_FORCE0   = 2'h2;
  localparam logic [1:0] SUB_FORCE1   = 2'h3;

  // Ping-pong turn, one-hot
  typedef enum logic [1:0] {
    PP_SHORT = 2'b01,
    PP_LONG  = 2'b10
  } dcm_turn_t;

  // Shared control register layout
  typedef struct packed {
    logic       demod;      // 0 transmit, 1 demodulation
    logic       pinSel;     // Pin 6 route or demod input select
    logic [1:0] func;       // Combine function or edge select
    logic [1:0] submode;    // Transmit submode
    logic       bit1;       // Initial short output or rising flag
    logic       bit0;       // Initial long output or falling flag
  } dcm_ctrl_t;

  // Register port request
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } dcm_bus_t;

  // Write hit decode
  function automatic logic busWrite(input dcm_bus_t b, input logic [AW-1:0] a);
    return b.wr && (b.addr == a);
  endfunction

  // Combine the two counter outputs
  function automatic logic combine(input logic [1:0] f, input logic a, input logic b);
    case (f)
      FN_AND:  return a & b;
      FN_OR:   return a | b;
      FN_NOR:  return ~(a | b);
      default: return ~(a & b);
    endcase
  endfunction

endpackage

/* File: design/dcm_pin_sync.sv */
// Three-stage pin synchronisers with agreement filter
`timescale 1ns/10ps
module dcm_pin_sync #(
  parameter int N = 2
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [N-1:0] pinRaw,
  output logic      [N-1:0] pinLvl_q
);

  // ----------------------------------------
  // One chain per pin
  // ----------------------------------------
  for (genvar i = 0; i < N; i++) begin : gSync
    logic s1_q;
    logic s2_q;
    logic s3_q;
    // Level only moves once stages two and three agree
    always_ff @(posedge mclk) begin
      if (rst) begin
        s1_q        <= 1'b0;
        s2_q        <= 1'b0;
        s3_q        <= 1'b0;
        pinLvl_q[i] <= 1'b0;
      end else begin
        s1_q <= pinRaw[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          pinLvl_q[i] <= s3_q;
        end
      end
    end
  end

endmodule // dcm_pin_sync

/* File: design/dcm_irq_ctrl.sv */
// Sticky interrupt status, mask and level interrupt output
`timescale 1ns/10ps
module dcm_irq_ctrl (
  input  wire logic                       mclk,
  input  wire logic                       rst,
  input  wire logic [dcm_pkg::IRQ_W-1:0]  event_i,
  input  wire dcm_pkg::dcm_bus_t          busReq,
  output logic      [dcm_pkg::IRQ_W-1:0]  status_q,
  output logic      [dcm_pkg::IRQ_W-1:0]  mask_q,
  output logic                            irq_q
);
  import dcm_pkg::*;

  // ----------------------------------------
  // Status: write one clears, a new event wins
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      status_q <= '0;
    end else begin
      status_q <= event_i | (status_q &
                  ~(busWrite(busReq, ADDR_IRQ_STATUS) ? busReq.wdata[IRQ_W-1:0] : '0));
    end
  end

  // Mask register
  always_ff @(posedge mclk) begin
    if (rst) begin
      mask_q <= '0;
    end else if (busWrite(busReq, ADDR_IRQ_MASK)) begin
      mask_q <= busReq.wdata[IRQ_W-1:0];
    end
  end

  // Level output, one cycle behind the status
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

endmodule // dcm_irq_ctrl

/* File: design/dcm_top.sv */
// Dual counter mode control: counters, output combine, demodulator and registers
//
// Overview of operation
// R1 - Shared control top bit: 0 (reset) transmit mode, 1 demodulation mode.
// R2 - Bit 6: transmit routes combined output to pin 6; demod picks input pin.
// R3 - Bits 5:4: transmit AND/OR/NOR/NAND; demod falling/rising/both/reserved edge.
// R4 - Capture interrupt enable lets demod edge captures raise an interrupt.
// R5 - Counter interrupt enable lets each short counter timeout raise an interrupt.
// R6 - A control bit puts short counter output or port data on pin 4.
// R7 - Demod rising and falling edges set flags; writing one clears them.
// R8 - Short output starts at initial bit, holds opposite while disabled.
// R9 - Submode selects normal or ping-pong; 10 forces long output 0, 11 forces 1.
// R10 - Interrupt enables and pin selects are zero after reset.
`timescale 1ns/10ps
module dcm_top (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire dcm_pkg::dcm_bus_t busReq,
  output logic [dcm_pkg::DW-1:0] rdData_q,
  output logic                   irq_q,
  input  wire logic              port3Pin1In,
  input  wire logic              port2Pin0In,
  input  wire logic              port3Pin4Data,
  input  wire logic              port3Pin6Data,
  output logic                   port3Pin4Out_q,
  output logic                   port3Pin6Out_q
);
  import dcm_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  dcm_ctrl_t        ctrl_q;
  logic [7:0]       cntCtrl_q;
  logic [7:0]       shortRld_q;
  logic [15:0]      longRld_q;
  logic [7:0]       shortCnt_q;
  logic [15:0]      longCnt_q;
  logic [7:0]       capLo_q;
  logic [7:0]       capHi_q;
  logic             shortOut_q;
  logic             longOut_q;
  logic             shortEnDly_q;
  logic             longEnDly_q;
  logic             demodPrev_q;
  dcm_turn_t        turn_q;
  logic [1:0]       pinLvl;
  logic             demodLvl;
  logic             shortEn;
  logic             longEn;
  logic             pingPong;
  logic             shortRun;
  logic             longRun;
  logic             shortTimeout;
  logic             longTimeout;
  logic             riseEv;
  logic             fallEv;
  logic             captureEv;
  logic [IRQ_W-1:0] irqEvent;
  logic [IRQ_W-1:0] irqStatus;
  logic [IRQ_W-1:0] irqMask;

  // ----------------------------------------
  // Demodulator input pins
  // ----------------------------------------
  dcm_pin_sync #(
    .N (2)
  ) uPinSync (
    .mclk     (mclk),
    .rst      (rst),
    .pinRaw   ({port2Pin0In, port3Pin1In}),
    .pinLvl_q (pinLvl)
  );

  // Input choice; a change of selection may itself look like an edge
  assign demodLvl = ctrl_q.pinSel ? pinLvl[1] : pinLvl[0]; // R2

  // Edge detection, reserved code detects nothing
  always_ff @(posedge mclk) begin
    if (rst) begin
      demodPrev_q <= 1'b0;
    end else begin
      demodPrev_q <= demodLvl;
    end
  end

  assign riseEv = ctrl_q.demod && demodLvl && !demodPrev_q &&
                  (ctrl_q.func == EDGE_RISE || ctrl_q.func == EDGE_BOTH); // R3
  assign fallEv = ctrl_q.demod && !demodLvl && demodPrev_q &&
                  (ctrl_q.func == EDGE_FALL || ctrl_q.func == EDGE_BOTH); // R3
  assign captureEv = riseEv | fallEv;

  // ----------------------------------------
  // Shared control register
  // ----------------------------------------
  // In demod mode the low two bits are sticky flags; a set beats the clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= dcm_ctrl_t'(COMMON_RST); // R1
    end else begin
      if (busWrite(busReq, ADDR_COMMON)) begin
        ctrl_q.demod   <= busReq.wdata[7]; // R1
        ctrl_q.pinSel  <= busReq.wdata[6];
        ctrl_q.func    <= busReq.wdata[5:4];
        ctrl_q.submode <= busReq.wdata[3:2];
      end
      if (ctrl_q.demod) begin
        ctrl_q.bit1 <= riseEv | (ctrl_q.bit1 &
                       ~(busWrite(busReq, ADDR_COMMON) & busReq.wdata[1])); // R7
        ctrl_q.bit0 <= fallEv | (ctrl_q.bit0 &
                       ~(busWrite(busReq, ADDR_COMMON) & busReq.wdata[0])); // R7
      end else if (busWrite(busReq, ADDR_COMMON)) begin
        ctrl_q.bit1 <= busReq.wdata[1];
        ctrl_q.bit0 <= busReq.wdata[0];
      end
    end
  end

  // ----------------------------------------
  // Counter control and reload registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      cntCtrl_q <= CNT_CTRL_RST; // R10
    end else if (busWrite(busReq, ADDR_CNT_CTRL)) begin
      cntCtrl_q <= busReq.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      shortRld_q <= SHORT_RLD_RST;
      longRld_q  <= LONG_RLD_RST;
    end else begin
      if (busWrite(busReq, ADDR_SHORT_RLD)) begin
        shortRld_q <= busReq.wdata;
      end
      if (busWrite(busReq, ADDR_LONG_RLD_LO)) begin
        longRld_q[7:0] <= busReq.wdata;
      end
      if (busWrite(busReq, ADDR_LONG_RLD_HI)) begin
        longRld_q[15:8] <= busReq.wdata;
      end
    end
  end

  assign shortEn  = cntCtrl_q[CC_SHORT_EN];
  assign longEn   = cntCtrl_q[CC_LONG_EN];
  assign pingPong = !ctrl_q.demod && (ctrl_q.submode == SUB_PINGPONG); // R9

  // ----------------------------------------
  // Ping-pong turn
  // ----------------------------------------
  // Leaving the ping-pong setting drops back to independent counting
  always_ff @(posedge mclk) begin
    if (rst) begin
      turn_q <= PP_SHORT;
    end else if (!pingPong) begin
      turn_q <= PP_SHORT; // R9
    end else begin
      case (turn_q)
        PP_SHORT: begin
          if (shortTimeout) begin
            turn_q <= PP_LONG;
          end
        end
        PP_LONG: begin
          if (longTimeout) begin
            turn_q <= PP_SHORT;
          end
        end
        default: turn_q <= PP_SHORT;
      endcase
    end
  end

  assign shortRun = shortEn && (!pingPong || turn_q == PP_SHORT);
  assign longRun  = longEn && (!pingPong || turn_q == PP_LONG);
  assign shortTimeout = shortRun && (shortCnt_q == '0);
  assign longTimeout  = longRun && (longCnt_q == '0);

  // ----------------------------------------
  // Down counters
  // ----------------------------------------
  // Stopped counters sit at their reload value, ready to start
  always_ff @(posedge mclk) begin
    if (rst) begin
      shortCnt_q <= SHORT_RLD_RST;
    end else if (!shortEn) begin
      shortCnt_q <= shortRld_q;
    end else if (shortRun) begin
      shortCnt_q <= shortTimeout ? shortRld_q : shortCnt_q - 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      longCnt_q <= LONG_RLD_RST;
    end else if (!longEn) begin
      longCnt_q <= longRld_q;
    end else if (longRun) begin
      longCnt_q <= longTimeout ? longRld_q : longCnt_q - 16'h0001;
    end
  end

  // Start detection for the initial output level
  always_ff @(posedge mclk) begin
    if (rst) begin
      shortEnDly_q <= 1'b0;
      longEnDly_q  <= 1'b0;
    end else begin
      shortEnDly_q <= shortEn;
      longEnDly_q  <= longEn;
    end
  end

  // ----------------------------------------
  // Counter outputs
  // ----------------------------------------
  // Disabled output holds the inverse so the start gives a transition
  always_ff @(posedge mclk) begin
    if (rst) begin
      shortOut_q <= 1'b1;
    end else if (!shortEn) begin
      shortOut_q <= ~ctrl_q.bit1; // R8
    end else if (!shortEnDly_q) begin
      shortOut_q <= ctrl_q.bit1; // R8
    end else if (shortTimeout) begin
      shortOut_q <= ~shortOut_q;
    end
  end

  // Force settings override counting at once
  always_ff @(posedge mclk) begin
    if (rst) begin
      longOut_q <= 1'b1;
    end else if (!ctrl_q.demod && ctrl_q.submode == SUB_FORCE0) begin
      longOut_q <= 1'b0; // R9
    end else if (!ctrl_q.demod && ctrl_q.submode == SUB_FORCE1) begin
      longOut_q <= 1'b1; // R9
    end else if (!longEn) begin
      longOut_q <= ~ctrl_q.bit0;
    end else if (!longEnDly_q) begin
      longOut_q <= ctrl_q.bit0;
    end else if (longTimeout) begin
      longOut_q <= ~longOut_q;
    end
  end

  // ----------------------------------------
  // Pin outputs
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      port3Pin4Out_q <= 1'b0;
      port3Pin6Out_q <= 1'b0;
    end else begin
      port3Pin4Out_q <= cntCtrl_q[CC_PIN4_SEL] ? shortOut_q : port3Pin4Data; // R6
      port3Pin6Out_q <= (!ctrl_q.demod && ctrl_q.pinSel) ?
                        combine(ctrl_q.func, shortOut_q, longOut_q) : port3Pin6Data; // R2 R3
    end
  end

  // ----------------------------------------
  // Capture registers
  // ----------------------------------------
  // Long counter value taken on every detected edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      capLo_q <= '0;
      capHi_q <= '0;
    end else if (captureEv) begin
      capLo_q <= longCnt_q[7:0];
      capHi_q <= longCnt_q[15:8];
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign irqEvent[IRQ_TIMEOUT] = shortTimeout && cntCtrl_q[CC_CNT_IE]; // R5
  assign irqEvent[IRQ_CAPTURE] = captureEv && cntCtrl_q[CC_CAP_IE]; // R4

  dcm_irq_ctrl uIrq (
    .mclk     (mclk),
    .rst      (rst),
    .event_i  (irqEvent),
    .busReq   (busReq),
    .status_q (irqStatus),
    .mask_q   (irqMask),
    .irq_q    (irq_q)
  );

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Data only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge mclk) begin
    if (rst || !busReq.rd) begin
      rdData_q <= '0;
    end else begin
      case (busReq.addr)
        ADDR_CNT_CTRL:    rdData_q <= cntCtrl_q;
        ADDR_COMMON:      rdData_q <= ctrl_q;
        ADDR_SHORT_RLD:   rdData_q <= shortRld_q;
        ADDR_LONG_RLD_LO: rdData_q <= longRld_q[7:0];
        ADDR_LONG_RLD_HI: rdData_q <= longRld_q[15:8];
        ADDR_CAP_LO:      rdData_q <= capLo_q;
        ADDR_CAP_HI:      rdData_q <= capHi_q;
        ADDR_IRQ_STATUS:  rdData_q <= {{(DW-IRQ_W){1'b0}}, irqStatus};
        ADDR_IRQ_MASK:    rdData_q <= {{(DW-IRQ_W){1'b0}}, irqMask};
        default:          rdData_q <= '0;
      endcase
    end
  end

endmodule // dcm_top

/* File: tb/dcm_assertions.sv */
// Port-level checker for the dual counter mode control block
`timescale 1ns/10ps
module dcm_checker (
  input wire logic              mclk,
  input wire logic              rst,
  input wire dcm_pkg::dcm_bus_t busReq,
  input wire logic [dcm_pkg::DW-1:0] rdData_q,
  input wire logic              irq_q,
  input wire logic              port3Pin4Data,
  input wire logic              port3Pin6Data,
  input wire logic              port3Pin4Out_q,
  input wire logic              port3Pin6Out_q
);
  import dcm_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // Shadows of software writes
  // ----------------------------------------
  logic [7:0] ctrlShadow_q;
  logic [7:0] commShadow_q;
  logic [1:0] maskShadow_q;
  logic       quiet;
  logic       longIdle;
  logic       combExp;

  // Bits 1:0 of the shared register are only trusted in transmit mode
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrlShadow_q <= 8'h00;
      commShadow_q <= 8'h00;
      maskShadow_q <= 2'h0;
    end else if (busReq.wr) begin
      if (busReq.addr == ADDR_CNT_CTRL) ctrlShadow_q <= busReq.wdata;
      if (busReq.addr == ADDR_COMMON) commShadow_q <= busReq.wdata;
      if (busReq.addr == ADDR_IRQ_MASK) maskShadow_q <= busReq.wdata[1:0];
    end
  end

  // Expected idle outputs; settling needs a quiet spell without control writes
  assign quiet    = !(busReq.wr && busReq.addr <= ADDR_COMMON);
  assign longIdle = commShadow_q[3] ? commShadow_q[2] : ~commShadow_q[0];
  always_comb begin
    case (commShadow_q[5:4])
      FN_AND:  combExp = ~commShadow_q[1] & longIdle;
      FN_OR:   combExp = ~commShadow_q[1] | longIdle;
      FN_NOR:  combExp = ~(~commShadow_q[1] | longIdle);
      default: combExp = ~(~commShadow_q[1] & longIdle);
    endcase
  end

  a_read_idle_zero: assert property (!busReq.rd |=> rdData_q == 8'h00)
    else $error("read data not zero outside a read answer");
  a_unmapped_read: assert property (busReq.rd && busReq.addr > ADDR_IRQ_MASK |=> rdData_q == 8'h00)
    else $error("unmapped read returned nonzero data");
  a_ctrl_readback: assert property (
    busReq.rd && busReq.addr == ADDR_CNT_CTRL |=> rdData_q == ctrlShadow_q)
    else $error("counter control read back wrong");
  a_mode_readback: assert property (
    busReq.rd && busReq.addr == ADDR_COMMON |=> rdData_q[7:2] == commShadow_q[7:2])
    else $error("shared control read back wrong");
  a_pin4_port_data: assert property (
    quiet && !ctrlShadow_q[CC_PIN4_SEL] |=> port3Pin4Out_q == $past(port3Pin4Data))
    else $error("pin 4 does not follow port data");
  a_pin4_short_idle: assert property (
    (quiet && !commShadow_q[7] && ctrlShadow_q[CC_PIN4_SEL] && !ctrlShadow_q[CC_SHORT_EN])[*3]
    |-> port3Pin4Out_q == ~commShadow_q[1])
    else $error("idle short output not opposite of its initial level");
  a_pin6_port_data: assert property (
    quiet && (commShadow_q[7] || !commShadow_q[6]) |=> port3Pin6Out_q == $past(port3Pin6Data))
    else $error("pin 6 does not follow port data");
  a_pin6_combine: assert property (
    (quiet && commShadow_q[7:6] == 2'b01 && ctrlShadow_q[7:6] == 2'b00
     && commShadow_q[3:2] != SUB_PINGPONG)[*3] |-> port3Pin6Out_q == combExp)
    else $error("pin 6 combined output wrong");
  a_irq_masked_low: assert property ((maskShadow_q == 2'h0)[*2] |-> !irq_q)
    else $error("interrupt raised with all sources masked");
endmodule // dcm_checker

bind dcm_top dcm_checker dcm_checker_i (
  .mclk          (mclk),
  .rst           (rst),
  .busReq        (busReq),
  .rdData_q      (rdData_q),
  .irq_q         (irq_q),
  .port3Pin4Data (port3Pin4Data),
  .port3Pin6Data (port3Pin6Data),
  .port3Pin4Out_q(port3Pin4Out_q),
  .port3Pin6Out_q(port3Pin6Out_q)
);

/* File: tb/dcm_top_tb_top.sv */
// Self-checking testbench for the dual counter mode control block
`timescale 1ns/10ps
module dcm_top_tb_top;
  import dcm_pkg::*;
  logic          mclk = 1'b0;
  logic          rst = 1'b1;
  dcm_bus_t      busReq = '0;
  logic [DW-1:0] rdData_q;
  logic          irq_q;
  logic [1:0]    demodPin = 2'b00;  // [0] port3 pin1, [1] port2 pin0
  logic          pin4Data = 1'b0;
  logic          pin6Data = 1'b0;
  logic          pin4Out;
  logic          pin6Out;
  int            errCount = 0;
  int            samplesChecked = 0;
  logic [7:0]    d;
  logic [7:0]    expFlags;
  logic [15:0]   capExp;            // Long reload, which a stopped long counter holds

  always #25 mclk = ~mclk;

  dcm_top dcm_top_i (
    .mclk          (mclk),
    .rst           (rst),
    .busReq        (busReq),
    .rdData_q      (rdData_q),
    .irq_q         (irq_q),
    .port3Pin1In   (demodPin[0]),
    .port2Pin0In   (demodPin[1]),
    .port3Pin4Data (pin4Data),
    .port3Pin6Data (pin6Data),
    .port3Pin4Out_q(pin4Out),
    .port3Pin6Out_q(pin6Out)
  );

  // Port latch levels wander at random so the plain pin paths get exercised
  always @(posedge mclk) begin
    pin4Data <= 1'($urandom);
    pin6Data <= 1'($urandom);
  end

  // ----------------------------------------
  // Bus, compare and expectation helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wrReg(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    busReq.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rdReg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    busReq.rd <= 1'b0;
    #1 chk(rdData_q, exp);
  endtask

  function automatic logic comb(input logic [1:0] f, input logic a, input logic b);
    case (f)
      FN_AND:  return a & b;
      FN_OR:   return a | b;
      FN_NOR:  return ~(a | b);
      default: return ~(a & b);
    endcase
  endfunction

  // Code 11 detects nothing; an unselected pin never raises a flag
  function automatic logic [7:0] edgeFlags(input logic [1:0] e, input logic hit);
    if (!hit || e == 2'h3) return 8'h00;
    return (e == EDGE_FALL) ? 8'h01 : (e == EDGE_RISE) ? 8'h02 : 8'h03;
  endfunction

  task automatic testDone();
    $display("mismatches %0d, comparisons %0d", errCount, samplesChecked);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(98));
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rdReg(ADDR_CNT_CTRL, 8'h00);
    rdReg(ADDR_COMMON, 8'h00);
    rdReg(8'h3c, 8'h00);
    rdReg(ADDR_CAP_HI, 8'h00);
    chk({7'h0, irq_q}, 8'h00);
    // Random transmit-mode settings read back whole
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom) & 8'h7f;
      wrReg(ADDR_COMMON, d);
      rdReg(ADDR_COMMON, d);
    end
    // Every combine function, idle level and long force on pin 6
    for (int s = 0; s < 3; s++) begin
      for (int k = 0; k < 16; k++) begin
        d = {2'b01, k[3:2], (s == 0) ? 2'b00 : 2'(s + 1), k[1:0]};
        wrReg(ADDR_COMMON, d);
        waitCyc(4);
        chk({7'h0, pin6Out}, {7'h0, comb(d[5:4], ~d[1], d[3] ? d[2] : ~d[0])});
      end
    end
    // Short output on pin 4: opposite level while idle, initial level on start
    wrReg(ADDR_SHORT_RLD, 8'h10);
    wrReg(ADDR_COMMON, 8'h02);
    wrReg(ADDR_CNT_CTRL, 8'h01);
    waitCyc(4);
    chk({7'h0, pin4Out}, 8'h00);
    wrReg(ADDR_CNT_CTRL, 8'h83);
    waitCyc(3);
    chk({7'h0, pin4Out}, 8'h01);
    // Timeouts latch status while masked, then raise the line once unmasked
    waitCyc(40);
    chk({7'h0, irq_q}, 8'h00);
    rdReg(ADDR_IRQ_STATUS, 8'h01);
    wrReg(ADDR_IRQ_MASK, 8'h01);
    waitCyc(3);
    chk({7'h0, irq_q}, 8'h01);
    wrReg(ADDR_CNT_CTRL, 8'h00);
    wrReg(ADDR_IRQ_STATUS, 8'h01);
    waitCyc(3);
    chk({7'h0, irq_q}, 8'h00);
    // Demodulation: each input select, driven pin and edge code
    wrReg(ADDR_CNT_CTRL, 8'h04);
    wrReg(ADDR_IRQ_MASK, 8'h02);
    // Stopped long counter sits at a random reload, so every capture takes it
    capExp = 16'($urandom);
    wrReg(ADDR_LONG_RLD_LO, capExp[7:0]);
    wrReg(ADDR_LONG_RLD_HI, capExp[15:8]);
    for (int k = 0; k < 16; k++) begin
      d = {1'b1, k[0], k[2:1], 4'h0};
      wrReg(ADDR_COMMON, d);
      wrReg(ADDR_COMMON, d | 8'h03);
      wrReg(ADDR_IRQ_STATUS, 8'h03);
      demodPin[k[3]] <= 1'b1;
      waitCyc(8);
      demodPin[k[3]] <= 1'b0;
      waitCyc(8);
      expFlags = edgeFlags(k[2:1], k[0] == k[3]);
      rdReg(ADDR_COMMON, d | expFlags);
      rdReg(ADDR_IRQ_STATUS, {6'h0, |expFlags, 1'b0});
      chk({7'h0, irq_q}, {7'h0, |expFlags});
    end
    rdReg(ADDR_CAP_LO, capExp[7:0]);
    rdReg(ADDR_CAP_HI, capExp[15:8]);
    testDone();
  end
endmodule // dcm_top_tb_top
